// *** rsrg_top.v ***
// Reader status, read gate, default address load and indicator control
// Summary of operation
// - Config code at init loads default address
// - Active switching input starts a read
// - All codes enabled; interleaved only ten digits
// - Good decode content goes to host
// - Activation opens gate; source selectable
// - Scan strobe at 1000 per second
// - Two switching lines, each input or output
// - Flash green during init; reading blocked
// - Steady green once ready
// - Good read: green briefly off
// - No read: off, red briefly, green
// - Service mode orange; no host output
// - Warning flashes red; error steady red
// - Net off unreleased; flashes green initializing
// - Net steady green when host connected
// - Net flashes red comm error; steady on failure
`timescale 1ns/1ps
`include "rsrg_consts.vh"
module rsrg_top #(
  parameter FLASH_CYC = `RSRG_FLASH_CYC,
  parameter BLIP_CYC  = `RSRG_BLIP_CYC,
  parameter SCAN_CYC  = `RSRG_SCAN_CYC
) (
  // Clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        wb_err_o,
  // Switching lines
  input  wire [1:0]  sw_in_i,
  output wire [1:0]  sw_out_o,
  output wire [1:0]  sw_oe_o,
  // Reflector and host command activation
  input  wire        refl_blocked_i,
  input  wire        cmd_trig_i,
  // Decoder results
  input  wire        dec_valid_i,
  input  wire        dec_ok_i,
  input  wire [3:0]  dec_type_i,
  input  wire [7:0]  dec_len_i,
  input  wire [31:0] dec_data_i,
  // Host stream
  output reg         host_valid_o,
  output reg  [31:0] host_data_o,
  input  wire        host_ready_i,
  // Network status
  input  wire        link_up_i,
  input  wire        link_act_i,
  // Scanner
  output wire        gate_o,
  output wire        scan_o,
  // Indicators
  output wire        pwr_green_o,
  output wire        pwr_red_o,
  output wire        net_green_o,
  output wire        net_red_o,
  output wire        link_green_o,
  output wire        link_yellow_o,
  output wire        irq_o
);
  localparam [3:0] TYPE_I25 = 4'h0;
  localparam [2:0] ST_INIT  = 3'b001;
  localparam [2:0] ST_IDLE  = 3'b010;
  localparam [2:0] ST_GATE  = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  reg  [31:0] ctrl_q;
  reg  [15:0] codeen_q;
  reg  [31:0] ip_q;
  reg  [31:0] mask_q;
  reg  [4:0]  irq_st_q;
  reg  [4:0]  irq_en_q;
  reg  [31:0] scans_q;
  reg  [2:0]  st_q;
  reg  [31:0] flash_q;
  reg         flash_ph_q;
  reg  [31:0] scan_q;
  reg  [31:0] rd_d;
  wire        acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr  = acc & wb_we_i & (wb_sel_i == 4'hF);
  wire [1:0]  src = ctrl_q[`RSRG_C_SRC_LSB+1:`RSRG_C_SRC_LSB];
  wire        service = ctrl_q[`RSRG_C_SERVICE];
  wire        dev_err = ctrl_q[`RSRG_C_ERROR];
  wire        ready   = ctrl_q[`RSRG_C_INITDONE] & ~dev_err;

  ////////////////////////////////////////////////////////////////////////
  // Switching lines
  wire [1:0] sw_is_out = {ctrl_q[`RSRG_C_SW1_OUT], ctrl_q[`RSRG_C_SW0_OUT]};
  assign sw_oe_o  = sw_is_out;
  assign sw_out_o = {ctrl_q[`RSRG_C_SWO1], ctrl_q[`RSRG_C_SWO0]} & sw_is_out;
  wire sw_act = |(sw_in_i & ~sw_is_out);

  // Activation source select
  reg act;
  always @*
  begin
    case (src)
      `RSRG_SRC_CMD:  act = ctrl_q[`RSRG_C_CMDGATE] | cmd_trig_i;
      `RSRG_SRC_REFL: act = refl_blocked_i;
      default:        act = sw_act;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Gate state machine
  always @(posedge clk_i)
  begin
    if (rst_i)
      st_q <= ST_INIT;
    else if (ce_i)
    begin
      case (st_q)
        ST_INIT: if (ctrl_q[`RSRG_C_INITDONE]) st_q <= ST_IDLE;
        ST_IDLE: if (act && ready) st_q <= ST_GATE;
        ST_GATE: if (!act || !ready) st_q <= ST_IDLE;
        default: st_q <= ST_INIT;
      endcase
    end
  end
  // Laser reads the config code during init, decode gated otherwise
  wire in_init = st_q[0];
  wire gating  = st_q[2];
  assign gate_o = gating | in_init;
  wire gate_start = ce_i & st_q[1] & act & ready;

  ////////////////////////////////////////////////////////////////////////
  // Scan strobe
  always @(posedge clk_i)
  begin
    if (rst_i)
      scan_q <= 32'h0000_0000;
    else if (ce_i)
    begin
      if (!gate_o || scan_q == SCAN_CYC - 1)
        scan_q <= 32'h0000_0000;
      else
        scan_q <= scan_q + 32'h0000_0001;
    end
  end
  assign scan_o = gate_o & (scan_q == 32'h0000_0000);

  ////////////////////////////////////////////////////////////////////////
  // Decode acceptance
  wire type_en = codeen_q[dec_type_i];
  wire len_ok  = (dec_type_i != TYPE_I25) || (dec_len_i == `RSRG_I25_DIGITS);
  wire dv      = ce_i & dec_valid_i;
  wire good    = dv & gating & dec_ok_i & type_en & len_ok;
  wire noread  = dv & gating & ~(dec_ok_i & type_en & len_ok);
  wire cfg_hit = dv & in_init & dec_ok_i;
  wire to_host = good & ~service;
  wire drop    = to_host & host_valid_o & ~host_ready_i;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      host_valid_o <= 1'b0;
      host_data_o  <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      if (to_host && (!host_valid_o || host_ready_i))
      begin
        host_valid_o <= 1'b1;
        host_data_o  <= dec_data_i;
      end
      else if (host_ready_i)
        host_valid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flash timebase and brief indications
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flash_q    <= 32'h0000_0000;
      flash_ph_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (flash_q == FLASH_CYC - 1)
      begin
        flash_q    <= 32'h0000_0000;
        flash_ph_q <= ~flash_ph_q;
      end
      else
        flash_q <= flash_q + 32'h0000_0001;
    end
  end

  wire good_busy;
  wire nr_busy;
  wire nr_first;
  rsrg_blip #(.LEN(BLIP_CYC)) u_good (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .start_i      (good),
    .busy_o       (good_busy),
    .first_half_o ()
  );
  rsrg_blip #(.LEN(BLIP_CYC)) u_noread (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .start_i      (noread),
    .busy_o       (nr_busy),
    .first_half_o (nr_first)
  );

  ////////////////////////////////////////////////////////////////////////
  // Power/status indicator
  reg pg;
  reg pr;
  always @*
  begin
    pg = 1'b0;
    pr = 1'b0;
    if (dev_err)
      pr = 1'b1;
    else if (in_init)
      pg = flash_ph_q;
    else if (nr_busy)
      pr = ~nr_first;
    else if (good_busy)
      pg = 1'b0;
    else if (service)
    begin
      pg = 1'b1;
      pr = 1'b1;
    end
    else if (ctrl_q[`RSRG_C_WARN])
      pr = flash_ph_q;
    else
      pg = 1'b1;
  end
  assign pwr_green_o = pg;
  assign pwr_red_o   = pr;

  // Network indicator
  reg ng;
  reg nr;
  always @*
  begin
    ng = 1'b0;
    nr = 1'b0;
    if (!ctrl_q[`RSRG_C_NETREL])
      ng = 1'b0;
    else if (ctrl_q[`RSRG_C_NETERR])
      nr = 1'b1;
    else if (ctrl_q[`RSRG_C_COMERR])
      nr = flash_ph_q;
    else if (ctrl_q[`RSRG_C_NETOK])
      ng = 1'b1;
    else if (ctrl_q[`RSRG_C_NETINIT])
      ng = flash_ph_q;
  end
  assign net_green_o   = ng;
  assign net_red_o     = nr;
  assign link_green_o  = link_up_i & ~link_act_i;
  assign link_yellow_o = link_up_i & link_act_i & flash_ph_q;

  ////////////////////////////////////////////////////////////////////////
  // Registers and interrupts
  wire [4:0] ev;
  assign ev[`RSRG_EV_GOOD]   = good;
  assign ev[`RSRG_EV_NOREAD] = noread;
  assign ev[`RSRG_EV_CFG]    = cfg_hit;
  assign ev[`RSRG_EV_GATE]   = gate_start;
  assign ev[`RSRG_EV_DROP]   = drop;
  wire [4:0] clr = (wr && wb_adr_i == `RSRG_A_IRQ_CLR) ? wb_dat_i[4:0] : 5'h00;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q   <= `RSRG_CTRL_RST;
      codeen_q <= `RSRG_CODEEN_RST;
      ip_q     <= 32'h0000_0000;
      mask_q   <= 32'h0000_0000;
      irq_st_q <= 5'h00;
      irq_en_q <= 5'h00;
      scans_q  <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      irq_st_q <= (irq_st_q & ~clr) | ev;                        // set beats clear
      if (scan_o)
        scans_q <= scans_q + 32'h0000_0001;
      if (wr && wb_adr_i == `RSRG_A_CTRL)
        ctrl_q <= wb_dat_i;
      else if (wr && wb_adr_i == `RSRG_A_IRQ_EN)
        irq_en_q <= wb_dat_i[4:0];
      else if (wr && wb_adr_i == `RSRG_A_CODEEN)
        codeen_q <= wb_dat_i[15:0];
      else if (wr && wb_adr_i == `RSRG_A_IP)
        ip_q <= wb_dat_i;
      else if (wr && wb_adr_i == `RSRG_A_MASK)
        mask_q <= wb_dat_i;
      if (cfg_hit)
      begin
        ip_q   <= `RSRG_DEF_IP;
        mask_q <= `RSRG_DEF_MASK;
      end
    end
  end
  assign irq_o = |(irq_st_q & irq_en_q);

  always @*
  begin
    rd_d = 32'h0000_0000;
    if (wb_adr_i == `RSRG_A_CTRL)
      rd_d = ctrl_q;
    else if (wb_adr_i == `RSRG_A_STAT)
      rd_d = {25'h0, host_valid_o, link_up_i, gating, in_init, st_q[1], pwr_red_o, pwr_green_o};
    else if (wb_adr_i == `RSRG_A_IRQ_ST)
      rd_d = {27'h0, irq_st_q};
    else if (wb_adr_i == `RSRG_A_IRQ_EN)
      rd_d = {27'h0, irq_en_q};
    else if (wb_adr_i == `RSRG_A_IP)
      rd_d = ip_q;
    else if (wb_adr_i == `RSRG_A_MASK)
      rd_d = mask_q;
    else if (wb_adr_i == `RSRG_A_CODEEN)
      rd_d = {16'h0, codeen_q};
    else if (wb_adr_i == `RSRG_A_SCANS)
      rd_d = scans_q;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i)
        wb_dat_o <= rd_d;
    end
  end
  assign wb_err_o = 1'b0;
endmodule // rsrg_top

// *** rsrg_consts.vh ***
// Constants of the reader status and read-gate block
`ifndef RSRG_CONSTS_VH
`define RSRG_CONSTS_VH
`define RSRG_CLK_HZ        10000000
`define RSRG_SCAN_RATE     1000
`define RSRG_SCAN_CYC      (`RSRG_CLK_HZ / `RSRG_SCAN_RATE)
`define RSRG_FLASH_NS      250000000
`define RSRG_FLASH_CYC     (`RSRG_FLASH_NS / 100)
`define RSRG_BLIP_NS       100000000
`define RSRG_BLIP_CYC      (`RSRG_BLIP_NS / 100)
`define RSRG_I25_DIGITS    8'h0A
`define RSRG_DEF_IP        32'hC0A8_3C65
`define RSRG_DEF_MASK      32'hFFFF_FF00
`define RSRG_A_CTRL        6'h00
`define RSRG_A_STAT        6'h04
`define RSRG_A_IRQ_ST      6'h08
`define RSRG_A_IRQ_EN      6'h0C
`define RSRG_A_IRQ_CLR     6'h10
`define RSRG_A_IP          6'h14
`define RSRG_A_MASK        6'h18
`define RSRG_A_CODEEN      6'h1C
`define RSRG_A_SCANS       6'h20
`define RSRG_CTRL_RST      32'h0000_0000
`define RSRG_CODEEN_RST    16'hFFFF
`define RSRG_C_INITDONE    0
`define RSRG_C_SERVICE     1
`define RSRG_C_WARN        2
`define RSRG_C_ERROR       3
`define RSRG_C_NETREL      4
`define RSRG_C_NETINIT     5
`define RSRG_C_NETOK       6
`define RSRG_C_COMERR      7
`define RSRG_C_NETERR      8
`define RSRG_C_SRC_LSB     9
`define RSRG_C_CMDGATE     11
`define RSRG_C_SW0_OUT     12
`define RSRG_C_SW1_OUT     13
`define RSRG_C_SWO0        14
`define RSRG_C_SWO1        15
`define RSRG_SRC_SWITCH    2'd0
`define RSRG_SRC_CMD       2'd1
`define RSRG_SRC_REFL      2'd2
`define RSRG_EV_GOOD       0
`define RSRG_EV_NOREAD     1
`define RSRG_EV_CFG        2
`define RSRG_EV_GATE       3
`define RSRG_EV_DROP       4
`endif

// *** rsrg_blip.v ***
// Retriggerable one-shot timer for brief indicator phases
`timescale 1ns/1ps
module rsrg_blip #(
  parameter LEN = 1000000
) (
  // Clock and control
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  // Trigger and state
  input  wire start_i,
  output wire busy_o,
  output wire first_half_o
);
  reg [31:0] cnt_q;
  always @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= 32'h0000_0000;
    else if (ce_i)
    begin
      if (start_i)
        cnt_q <= LEN;
      else if (cnt_q != 32'h0000_0000)
        cnt_q <= cnt_q - 32'h0000_0001;
    end
  end
  assign busy_o       = (cnt_q != 32'h0000_0000);
  assign first_half_o = (cnt_q > (LEN / 2));
endmodule // rsrg_blip

// *** rsrg_host_model.sv ***
// Host receiver model for the decoded-content stream
`timescale 1ns/1ps
module rsrg_host_model (
  // Clock and control
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        stall_i,
  // Stream from the reader
  input  wire        valid_i,
  input  wire [31:0] data_i,
  output wire        ready_o,
  // Observed words
  output reg  [31:0] last_q,
  output reg  [7:0]  cnt_q
);
  // Stall builds backpressure on demand, as a busy host would
  assign ready_o = !stall_i;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_q <= 32'h0000_0000;
      cnt_q  <= 8'h00;
    end
    else if (valid_i && ready_o)
    begin
      last_q <= data_i;
      cnt_q  <= cnt_q + 8'h01;
    end
  end
endmodule // rsrg_host_model

// *** rsrg_top_sva.sv ***
// Port assertions for the reader status and read-gate block
`timescale 1ns/1ps
module rsrg_chk (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  input wire        ce_i,
  // Bus and host stream
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire        host_valid_o,
  input wire [31:0] host_data_o,
  input wire        host_ready_i,
  // Lines, gate, indicators
  input wire [1:0]  sw_oe_o,
  input wire        gate_o,
  input wire        scan_o,
  input wire        pwr_red_o,
  input wire        link_up_i,
  input wire        link_green_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  a_ack_next:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o) else $error("no ack");
  a_ack_single:
    assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
  a_host_hold:
    assert property (host_valid_o && !host_ready_i && ce_i |=> host_valid_o
      && $stable(host_data_o)) else $error("host word lost");
  a_scan_gated:
    assert property (scan_o |-> gate_o) else $error("scan outside gate");
  a_scan_pulse:
    assert property (scan_o && ce_i |=> !scan_o) else $error("scan not a pulse");
  a_reset_state:
    assert property ($past(rst_i) |-> sw_oe_o == 2'h0 && !host_valid_o && !wb_ack_o && gate_o)
      else $error("bad state after reset");
  a_init_gate:
    assert property ($fell(rst_i) |-> (gate_o && !pwr_red_o) [*4]) else $error("init wrong");
  a_link_down:
    assert property (!link_up_i && $stable(link_up_i) |-> !link_green_o) else $error("link");
  c_stall: cover property (host_valid_o && !host_ready_i);
  c_scan: cover property (scan_o);
  c_ack: cover property (wb_ack_o);
endmodule // rsrg_chk
////////////////////////////////////////
bind rsrg_top rsrg_chk i_rsrg_chk (
  .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .host_valid_o, .host_data_o,
  .host_ready_i, .sw_oe_o, .gate_o, .scan_o, .pwr_red_o, .link_up_i, .link_green_o
);

// *** rsrg_top_tb_top.sv ***
// Self-checking bench for the reader status and read-gate block
`timescale 1ns/1ps
`include "rsrg_consts.vh"
module rsrg_top_tb_top;
  reg         clk, rst, cyc, we, dv, dok, stall, cmd, lup, lact, ce, refl;
  reg  [5:0]  adr;
  reg  [31:0] wdat, ddat, rd;
  reg  [1:0]  sw;
  reg  [3:0]  dtyp, hi, lo;
  reg  [7:0]  dlen, c0;
  reg  [13:0] rows [0:4];
  integer     err_count, tests_run, i;
  wire [31:0] rdat, hd, last;
  wire [7:0]  cnt;
  wire [1:0]  swo, swoe;
  wire        ack, hv, rdy, gate, pg, pr, ng, nr, lg, irq, scn, ly, err;
  ////////////////////////////////////////
  always #50 clk = ~clk;
  rsrg_top #(.FLASH_CYC(8), .BLIP_CYC(8), .SCAN_CYC(4)) i_rsrg_top (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .sw_in_i(sw), .sw_out_o(swo), .sw_oe_o(swoe), .refl_blocked_i(refl),
    .cmd_trig_i(cmd), .dec_valid_i(dv), .dec_ok_i(dok), .dec_type_i(dtyp),
    .dec_len_i(dlen), .dec_data_i(ddat), .host_valid_o(hv), .host_data_o(hd),
    .host_ready_i(rdy), .link_up_i(lup), .link_act_i(lact), .gate_o(gate), .scan_o(scn),
    .pwr_green_o(pg), .pwr_red_o(pr), .net_green_o(ng), .net_red_o(nr),
    .link_green_o(lg), .link_yellow_o(ly), .irq_o(irq));
  rsrg_host_model i_rsrg_host_model (.clk_i(clk), .rst_i(rst), .stall_i(stall),
    .valid_i(hv), .data_i(hd), .ready_o(rdy), .last_q(last), .cnt_q(cnt));
  ////////////////////////////////////////
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input [79:0] nm, input [31:0] s, input [31:0] e);
    tests_run = tests_run + 1;
    if (s !== e)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task wb(input w, input [5:0] a, input [31:0] d);
    @(posedge clk);
    {cyc, we, adr, wdat} <= {1'b1, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
  endtask
  task rc(input [5:0] a, input [31:0] e, input [79:0] nm);
    wb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // Decoder result: ok, type, digits, content
  task dec(input [44:0] v);
    @(posedge clk);
    {dok, dtyp, dlen, ddat, dv} <= {v, 1'b1};
    @(posedge clk);
    dv <= 1'b0;
  endtask
  // Flashing shows as both levels seen within the span
  task watch;
    hi = 4'h0;
    lo = 4'h0;
    repeat (24)
    begin
      @(posedge clk);
      hi = hi | {pg, pr, ng, nr};
      lo = lo | ~{pg, pr, ng, nr};
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #1000000;
    err_count = err_count + 1;
    final_report;
  end
  initial
  begin
    {clk, rst, cyc, we, dv, dok, stall, cmd, lup, lact} = 10'h100;
    {adr, wdat, ddat, sw, dtyp, dlen} = 84'h0;
    ce = 1'b1;
    refl = 1'b0;
    err_count = 0;
    tests_run = 0;
    // Row: ok, type, digits, good read expected
    rows[0] = 14'h2015;
    rows[1] = 14'h2012;
    rows[2] = 14'h2016;
    rows[3] = 14'h2A09;
    rows[4] = 14'h040C;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk("reset", 32'({swoe, gate, hv}), 32'h2);
    watch;
    chk("init", 32'({hi, lo}), 32'h8F);
    rc(`RSRG_A_CTRL, 32'h0, "ctrl");
    rc(`RSRG_A_CODEEN, 32'hFFFF, "codeen");
    dec({13'h1305, 32'h0000_0001});
    tick(2);
    rc(`RSRG_A_IP, `RSRG_DEF_IP, "ip");
    rc(`RSRG_A_MASK, `RSRG_DEF_MASK, "mask");
    wb(1'b1, `RSRG_A_IRQ_EN, 32'h1F);
    wb(1'b1, `RSRG_A_CTRL, 32'h51);
    tick(2);
    chk("ready", 32'({gate, pg, pr, ng, nr}), 32'hA);
    sw <= 2'h3;
    tick(3);
    chk("gate", 32'(gate), 32'h1);
    wb(1'b1, `RSRG_A_IRQ_CLR, 32'h1F);
    for (i = 0; i < 5; i = i + 1)
    begin
      c0 = cnt;
      dec({rows[i][13:1], 32'hA5A5_0000 + i});
      tick(4);
      chk("off", 32'({pg, pr}), 32'h0);
      tick(4);
      chk("red", 32'(pr), 32'(!rows[i][0]));
      tick(12);
      chk("green", 32'({pg, pr}), 32'h2);
      chk("hostcnt", 32'(cnt - c0), 32'(rows[i][0]));
      rc(`RSRG_A_IRQ_ST, rows[i][0] ? 32'h1 : 32'h2, "irqst");
      wb(1'b1, `RSRG_A_IRQ_CLR, 32'h1F);
      $display("row %0d done", i);
    end
    chk("lastdat", last, 32'hA5A5_0003);
    dec({13'h100A, 32'h0000_00D0});
    tick(3);
    chk("irqset", 32'(irq), 32'h1);
    wb(1'b1, `RSRG_A_IRQ_EN, 32'h0);
    tick(2);
    chk("irqmask", 32'(irq), 32'h0);
    wb(1'b1, `RSRG_A_IRQ_EN, 32'h1F);
    wb(1'b1, `RSRG_A_IRQ_CLR, 32'h1F);
    tick(2);
    chk("irqclr", 32'(irq), 32'h0);
    // Second word arrives while the first is still unaccepted
    stall <= 1'b1;
    c0 = cnt;
    dec({13'h100A, 32'h0000_00D1});
    dec({13'h100A, 32'h0000_00D2});
    tick(2);
    chk("hold", hd, 32'hD1);
    rc(`RSRG_A_IRQ_ST, 32'h11, "drop");
    stall <= 1'b0;
    tick(2);
    chk("drain", 32'(cnt - c0), 32'h1);
    wb(1'b1, `RSRG_A_CODEEN, 32'hFFFD);
    wb(1'b1, `RSRG_A_IRQ_CLR, 32'h1F);
    dec({13'h1105, 32'h0000_00E1});
    tick(3);
    rc(`RSRG_A_IRQ_ST, 32'h2, "codeoff");
    wb(1'b1, `RSRG_A_CTRL, 32'h53);
    c0 = cnt;
    dec({13'h100A, 32'h0000_00E2});
    tick(20);
    chk("service", 32'({pg, pr, cnt - c0}), 32'h300);
    wb(1'b1, `RSRG_A_CTRL, 32'h35);
    watch;
    chk("warn", 32'({hi[2:0], lo[2:1]}), 32'h1B);
    wb(1'b1, `RSRG_A_CTRL, 32'h119);
    watch;
    chk("error", 32'({hi, lo}), 32'h5A);
    wb(1'b1, `RSRG_A_CTRL, 32'h91);
    watch;
    chk("comm", 32'({hi[1:0], lo[0]}), 32'h3);
    // Reflector source: blocked beam opens the gate, clear beam closes it
    wb(1'b1, `RSRG_A_CTRL, 32'h451);
    refl <= 1'b1;
    tick(3);
    chk("reflon", 32'(gate), 32'h1);
    refl <= 1'b0;
    tick(3);
    chk("refloff", 32'(gate), 32'h0);
    wb(1'b1, `RSRG_A_CTRL, 32'h5201);
    sw <= 2'h0;
    cmd <= 1'b1;
    tick(3);
    chk("cmdgate", 32'({gate, swoe, swo[0]}), 32'hB);
    // Any eight cycles of an open gate hold exactly two scan strobes
    c0 = 8'h00;
    repeat (8)
    begin
      @(posedge clk);
      c0 = c0 + {7'h00, scn};
    end
    chk("scan", 32'(c0), 32'h2);
    cmd <= 1'b0;
    tick(3);
    chk("cmdoff", 32'(gate), 32'h0);
    rc(6'h3C, 32'h0, "unmapped");
    chk("buserr", 32'(err), 32'h0);
    lup <= 1'b1;
    tick(2);
    chk("link", 32'(lg), 32'h1);
    lact <= 1'b1;
    hi = 4'h0;
    lo = 4'h0;
    repeat (24)
    begin
      @(posedge clk);
      hi[0] = hi[0] | ly;
      lo[0] = lo[0] | ~ly;
    end
    chk("activity", 32'({lg, hi[0], lo[0]}), 32'h3);
    // Flash phase toggles every eight cycles unless the enable freezes it
    ce <= 1'b0;
    tick(1);
    c0 = {7'h00, ly};
    tick(8);
    chk("freeze", 32'(ly), 32'(c0));
    ce <= 1'b1;
    // Reset in mid-run returns to init with the address cleared
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    chk("rereset", 32'({swoe, gate, hv}), 32'h2);
    rc(`RSRG_A_IP, 32'h0, "ipreset");
    final_report;
  end
endmodule // rsrg_top_tb_top
